// ### verilog/cct_timers.sv
`timescale 1ns/1ps
// Contract
// RL1 - Three identical timers, 32-bit count, preset period, 16-bit prescaler.
// RL2 - Counters count down and request an interrupt on reaching zero.
// RL3 - One decrement per prescaled tick: clock divided by prescale setting.
// RL4 - At zero the counter reloads its period and keeps counting.
// RL5 - First timer interrupt goes to the interrupt expander only.
// RL6 - Second timer interrupt can be connected to CPU line 13.
// RL7 - Third timer interrupt drives CPU line 14.
// RL8 - Third timer clocks from system clock (default), two oscillators or external.
// RL9 - Software sets period and prescale first and acknowledges each interrupt.
module cct_timers #(
	parameter int COUNT_W = cct_pkg::COUNT_W,
	parameter int PRESCALE_W = cct_pkg::PRESCALE_W
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// Timer configuration, one group per timer
	input wire logic [2:0] RUN,
	input wire logic [COUNT_W-1:0] PERIOD_0,
	input wire logic [COUNT_W-1:0] PERIOD_1,
	input wire logic [COUNT_W-1:0] PERIOD_2,
	input wire logic [PRESCALE_W-1:0] PRESCALE_0,
	input wire logic [PRESCALE_W-1:0] PRESCALE_1,
	input wire logic [PRESCALE_W-1:0] PRESCALE_2,
	// Timer 1 routing to CPU line 13
	input wire logic LINE13_CONNECT,
	// Timer 2 clock source select and source ticks, synchronous one-cycle enables
	input wire logic [1:0] SRC_SELECT,
	input wire logic INTERNAL_OSCILLATOR_ONE,
	input wire logic INTERNAL_OSCILLATOR_TWO,
	input wire logic EXTERNAL_CLOCK,
	// Counts
	output logic [COUNT_W-1:0] COUNT_0,
	output logic [COUNT_W-1:0] COUNT_1,
	output logic [COUNT_W-1:0] COUNT_2,
	// Interrupt requests, one-cycle pulses
	output logic INTERRUPT_EXPANDER_REQ,
	output logic CPU_IRQ_LINE_13,
	output logic CPU_IRQ_LINE_14
);

	logic [COUNT_W-1:0] period [3];
	logic [PRESCALE_W-1:0] prescale [3];
	logic [COUNT_W-1:0] count [3];
	logic [2:0] zero;
	logic [2:0] tick;
	logic [1:0] src_sel;
	logic src_tick;
	logic next_exp_req;
	logic next_line13;
	logic next_line14;
	logic [7:0] zero_tally;
	logic [7:0] req_tally;

	assign period[0] = PERIOD_0;
	assign period[1] = PERIOD_1;
	assign period[2] = PERIOD_2;
	assign prescale[0] = PRESCALE_0;
	assign prescale[1] = PRESCALE_1;
	assign prescale[2] = PRESCALE_2;

	// Selected source for timer 2; the source ticks are enables, so one clock domain
	assign src_tick = (src_sel == cct_pkg::CCT_SRC_OSC_ONE) ? INTERNAL_OSCILLATOR_ONE :
		(src_sel == cct_pkg::CCT_SRC_OSC_TWO) ? INTERNAL_OSCILLATOR_TWO :
		(src_sel == cct_pkg::CCT_SRC_EXTERNAL) ? EXTERNAL_CLOCK : 1'b1; // RL8
	assign tick = {src_tick, 2'b11};

	// Source select register, system clock after reset
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			src_sel <= cct_pkg::SRC_RESET; // RL8
		end else begin
			src_sel <= SRC_SELECT;
		end
	end

	// Three identical timers
	for (genvar i = 0; i < cct_pkg::NUM_TIMERS; i++) begin : g_tmr // RL1
		cct_timer #(
			.COUNT_W(COUNT_W),
			.PRESCALE_W(PRESCALE_W)
		) u_tmr (
			.clk(REF_CLK),
			.rst_n(RESETN),
			.tick_in(tick[i]),
			.run(RUN[i]),
			.period(period[i]),
			.prescale(prescale[i]),
			.count(count[i]),
			.zero_pulse(zero[i])
		);
	end

	// Counts are already flip-flop outputs of the timers
	assign COUNT_0 = count[0];
	assign COUNT_1 = count[1];
	assign COUNT_2 = count[2];

	// Routed requests; line 13 is gated here so a parked connection stays quiet
	assign next_exp_req = zero[0]; // RL5
	assign next_line13 = zero[1] && LINE13_CONNECT; // RL6
	assign next_line14 = zero[2]; // RL7

	// Interrupt outputs registered once more; acknowledge lives in the controller
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			INTERRUPT_EXPANDER_REQ <= 1'b0;
			CPU_IRQ_LINE_13 <= 1'b0;
			CPU_IRQ_LINE_14 <= 1'b0;
		end else begin
			INTERRUPT_EXPANDER_REQ <= next_exp_req; // RL5
			CPU_IRQ_LINE_13 <= next_line13; // RL6
			CPU_IRQ_LINE_14 <= next_line14; // RL7
		end
	end

	// Check-only tallies: a request may trail its zero by one edge, never more
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			zero_tally <= 8'h00;
			req_tally <= 8'h00;
		end else begin
			zero_tally <= zero_tally + 8'(zero[0]);
			req_tally <= req_tally + 8'(INTERRUPT_EXPANDER_REQ);
		end
	end

	a_exp_route: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL5
		zero[0] |=> INTERRUPT_EXPANDER_REQ)
		else $error("timer 0 request not routed");
	a_line13_gate: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL6
		CPU_IRQ_LINE_13 |-> $past(zero[1]) && $past(LINE13_CONNECT))
		else $error("line 13 without timer 1 zero");
	a_line14_route: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL7
		zero[2] |=> CPU_IRQ_LINE_14)
		else $error("timer 2 request not routed");
	a_src_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL8
		src_sel == cct_pkg::CCT_SRC_EXTERNAL && !EXTERNAL_CLOCK && RUN[2]
		|=> COUNT_2 == $past(COUNT_2))
		else $error("timer 2 counted without external tick");
	a_osc_one_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL8
		src_sel == cct_pkg::CCT_SRC_OSC_ONE && !INTERNAL_OSCILLATOR_ONE
		|=> COUNT_2 == $past(COUNT_2))
		else $error("timer 2 counted without oscillator one tick");
	a_osc_two_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL8
		src_sel == cct_pkg::CCT_SRC_OSC_TWO && !INTERNAL_OSCILLATOR_TWO
		|=> COUNT_2 == $past(COUNT_2))
		else $error("timer 2 counted without oscillator two tick");
	a_zero_tick: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL8
		zero[2] |-> $past(tick[2]))
		else $error("timer 2 reached zero without a source tick");

	// The source select is a plain register: its input shows one edge later
	a_src_follow: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL8
		$past(RESETN) |-> src_sel == $past(SRC_SELECT))
		else $error("source select did not follow its input");

	// A reset cycle brings back all-ones counts, quiet requests and the system clock
	a_reset_counts: assert property (@(posedge REF_CLK) // RL1
		!RESETN |=> COUNT_0 == COUNT_W'(cct_pkg::COUNT_RESET)
		&& COUNT_1 == COUNT_W'(cct_pkg::COUNT_RESET)
		&& COUNT_2 == COUNT_W'(cct_pkg::COUNT_RESET))
		else $error("counts not at reset value");
	a_reset_quiet: assert property (@(posedge REF_CLK) // RL2
		!RESETN |=> !INTERRUPT_EXPANDER_REQ && !CPU_IRQ_LINE_13 && !CPU_IRQ_LINE_14)
		else $error("request raised during reset");
	a_reset_source: assert property (@(posedge REF_CLK) // RL8
		!RESETN |=> src_sel == cct_pkg::SRC_RESET)
		else $error("source select not back at system clock");

	// Each request traces back to its own timer and lasts one cycle unless renewed
	a_exp_cause: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL5
		INTERRUPT_EXPANDER_REQ |-> $past(zero[0]))
		else $error("expander request without timer 0 zero");
	a_exp_single: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL5
		INTERRUPT_EXPANDER_REQ && !zero[0] |=> !INTERRUPT_EXPANDER_REQ)
		else $error("expander request held too long");
	a_exp_no_loss: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL5
		8'(zero_tally - req_tally) <= 8'h01)
		else $error("expander request lost");
	a_line13_pass: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL6
		zero[1] && LINE13_CONNECT |=> CPU_IRQ_LINE_13)
		else $error("timer 1 zero not passed to line 13");
	a_line13_block: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL6
		!LINE13_CONNECT |=> !CPU_IRQ_LINE_13)
		else $error("line 13 raised while disconnected");
	a_line13_single: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL6
		CPU_IRQ_LINE_13 && !zero[1] |=> !CPU_IRQ_LINE_13)
		else $error("line 13 request held too long");
	a_line14_cause: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL7
		CPU_IRQ_LINE_14 |-> $past(zero[2]))
		else $error("line 14 without timer 2 zero");
	a_line14_single: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL7
		CPU_IRQ_LINE_14 && !zero[2] |=> !CPU_IRQ_LINE_14)
		else $error("line 14 request held too long");

	// Per-timer view from the top: parked timers freeze, counts only step or reload
	for (genvar i = 0; i < cct_pkg::NUM_TIMERS; i++) begin : g_chk // RL1
		a_run_freeze: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL3
			!RUN[i] |=> count[i] == $past(count[i]))
			else $error("parked timer moved");
		a_idle_quiet: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL2
			!RUN[i] |=> !zero[i])
			else $error("parked timer reached zero");
		a_pulse_from_one: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL2
			zero[i] |-> $past(count[i]) == COUNT_W'(1))
			else $error("zero pulse not from a count of one");
		a_reload_value: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL4
			zero[i] |-> count[i] == $past(period[i]))
			else $error("timer did not reload its period");
		a_count_step: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RL4
			$past(RESETN) && count[i] != $past(count[i])
			|-> count[i] == $past(count[i]) - 1'b1 || count[i] == $past(period[i]))
			else $error("count moved by other than a step or reload");
	end

	c_exp: cover property (@(posedge REF_CLK) INTERRUPT_EXPANDER_REQ);
	c_line13: cover property (@(posedge REF_CLK) CPU_IRQ_LINE_13);
	c_line14: cover property (@(posedge REF_CLK) CPU_IRQ_LINE_14);
	c_src_ext: cover property (@(posedge REF_CLK)
		src_sel == cct_pkg::CCT_SRC_EXTERNAL && EXTERNAL_CLOCK && RUN[2]);

endmodule : cct_timers

// ### verilog/cct_pkg.sv
package cct_pkg;

	// Counter and prescaler widths, and the number of timers
	localparam int COUNT_W = 32;
	localparam int PRESCALE_W = 16;
	localparam int NUM_TIMERS = 3;

	// Reset values of the configuration inputs are taken live; state resets
	localparam logic [31:0] COUNT_RESET = 32'hffff_ffff;
	localparam logic [15:0] PRESCALE_RESET = 16'h0000;

	// Timer 2 clock source selection
	typedef enum logic [1:0] {
		CCT_SRC_SYSCLK,
		CCT_SRC_OSC_ONE,
		CCT_SRC_OSC_TWO,
		CCT_SRC_EXTERNAL
	} cct_src_e;

	localparam logic [1:0] SRC_RESET = 2'h0;

endpackage : cct_pkg

// ### verilog/cct_timer.sv
`timescale 1ns/1ps
// One down-counting timer with prescaler and automatic reload
module cct_timer #(
	parameter int COUNT_W = cct_pkg::COUNT_W,
	parameter int PRESCALE_W = cct_pkg::PRESCALE_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Tick source and configuration
	input wire logic tick_in,
	input wire logic run,
	input wire logic [COUNT_W-1:0] period,
	input wire logic [PRESCALE_W-1:0] prescale,
	// Status
	output logic [COUNT_W-1:0] count,
	output logic zero_pulse
);

	logic [PRESCALE_W-1:0] pre_cnt;
	logic [PRESCALE_W-1:0] next_pre_cnt;
	logic [COUNT_W-1:0] next_count;
	logic dec_tick;
	logic at_zero;
	logic [COUNT_W-1:0] count_m1;

	// Prescaler: a setting of 0 or 1 both give a tick on every source edge
	assign dec_tick = run && tick_in && (pre_cnt == '0); // RL3
	assign next_pre_cnt = !(run && tick_in) ? pre_cnt :
		(pre_cnt == '0) ? ((prescale == '0) ? '0 : prescale - 1'b1) : pre_cnt - 1'b1;
	assign count_m1 = count - 1'b1;
	assign at_zero = dec_tick && (count_m1 == '0);
	// Reload replaces the zero count so a period of N gives N ticks per interrupt
	assign next_count = !dec_tick ? count : (count == '0 || at_zero) ? period : count_m1; // RL4

	// Counter and prescaler state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pre_cnt <= PRESCALE_W'(cct_pkg::PRESCALE_RESET);
			count <= COUNT_W'(cct_pkg::COUNT_RESET);
			zero_pulse <= 1'b0;
		end else begin
			pre_cnt <= next_pre_cnt;
			count <= next_count; // RL2
			zero_pulse <= at_zero; // RL2
		end
	end

	a_zero_reload: assert property (@(posedge clk) disable iff (!rst_n) // RL4
		at_zero |=> count == $past(period))
		else $error("timer did not reload at zero");
	a_count_down: assert property (@(posedge clk) disable iff (!rst_n) // RL2
		dec_tick && count > 32'h1 |=> count == $past(count) - 32'h1)
		else $error("timer did not decrement");
	a_hold_no_tick: assert property (@(posedge clk) disable iff (!rst_n) // RL3
		!dec_tick |=> count == $past(count))
		else $error("timer moved without a tick");
	a_pulse_cause: assert property (@(posedge clk) disable iff (!rst_n) // RL2
		zero_pulse |-> $past(dec_tick) && $past(count) == 32'h1)
		else $error("interrupt pulse without zero");
	c_reload: cover property (@(posedge clk) disable iff (!rst_n) at_zero);

endmodule : cct_timer

// ### bench/cct_irq_sink.sv
`timescale 1ns/1ps
// Interrupt inputs: each pulse is taken and counted at once
module cct_irq_sink (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request lines: expander, line 13, line 14
	input wire logic [2:0] irq,
	// Pulse totals
	output int hits [3]
);
	// Counting on the edge only, so a held level would be seen as many pulses
	always_ff @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (!rst_n) hits[i] <= 0;
			else if (irq[i] === 1'b1) hits[i] <= hits[i] + 1;
		end
	end
endmodule : cct_irq_sink

// ### bench/cpu_countdown_timers_tb.sv
`timescale 1ns/1ps
module cpu_countdown_timers_tb;
	logic clk = 0;
	logic rstn = 0;
	logic l13 = 0;
	logic tk;
	logic [1:0] ssel = 0, sel;
	logic [2:0] run = 0, osc = 0, cirq, q, z;
	logic [3:0] per [3] = '{default: 0}, cnt [3], c0, c1, c2;
	logic [15:0] pre [3] = '{default: 0}, pc [3];
	int error_cnt = 0, n_tests = 0, seed = 32'h680e, hits [3], want [3] = '{default: 0};

	// Narrow counter so the all-ones start value counts down to a reload within the run
	cct_timers #(.COUNT_W(4)) DUT (.REF_CLK(clk), .RESETN(rstn), .RUN(run),
		.PERIOD_0(per[0]), .PERIOD_1(per[1]), .PERIOD_2(per[2]),
		.PRESCALE_0(pre[0]), .PRESCALE_1(pre[1]), .PRESCALE_2(pre[2]),
		.LINE13_CONNECT(l13), .SRC_SELECT(ssel), .INTERNAL_OSCILLATOR_ONE(osc[0]),
		.INTERNAL_OSCILLATOR_TWO(osc[1]), .EXTERNAL_CLOCK(osc[2]), .COUNT_0(c0),
		.COUNT_1(c1), .COUNT_2(c2), .INTERRUPT_EXPANDER_REQ(cirq[0]),
		.CPU_IRQ_LINE_13(cirq[1]), .CPU_IRQ_LINE_14(cirq[2]));
	cct_irq_sink partner (.clk(clk), .rst_n(rstn), .irq(cirq), .hits(hits));

	always #12.5 clk = ~clk;

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	// Expected count after one decrement; reload stands in for reaching zero
	function automatic logic [3:0] exp_count(input logic [3:0] c, input logic [3:0] p);
		return (c <= 4'h1) ? p : c - 4'h1;
	endfunction : exp_count

	task automatic tally_and_finish;
		if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Reference timers: pulse is registered one edge after the reload
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			q[i] = z[i] & (i != 1 || l13);
			tk = (i < 2 || sel == 0) ? 1'b1 : osc[sel-1];
			z[i] = 0;
			if (run[i] && tk) begin
				if (pc[i] == 0) begin
					pc[i] = (pre[i] > 1) ? pre[i] - 1 : 0;
					z[i] = (cnt[i] == 1);
					cnt[i] = exp_count(cnt[i], per[i]);
				end else pc[i]--;
			end
			if (!rstn) {q[i], z[i], pc[i], cnt[i]} = {2'h0, 16'h0, 4'hf};
		end
		sel = rstn ? ssel : 2'h0;
	end

	// Compare where outputs have settled
	always @(negedge clk) if (rstn) begin
		chk("count", {cnt[2], cnt[1], cnt[0]}, {c2, c1, c0});
		chk("irq", q, cirq);
		for (int i = 0; i < 3; i++) want[i] += q[i];
	end

	// Random traffic; routing changes only while timers are parked
	initial begin
		repeat (6) @(posedge clk);
		#2 rstn = 1;
		for (int k = 0; k < 3000; k++) begin
			@(posedge clk);
			#2;
			run = (k % 128 < 4) ? 3'h0 : 3'($random(seed));
			if (k % 128 == 1) {l13, ssel} = 3'($random(seed));
			osc = 3'($random(seed));
			for (int i = 0; i < 3; i++) begin
				per[i] = 4'($random(seed));
				pre[i] = (k >= 1000 && k < 1100) ? 16'h1 : 16'({$random(seed)} % 4);
				if (k >= 1000 && k < 1100) per[i] = 4'h1;
			end
		end
		@(posedge clk);
		#2;
		for (int i = 0; i < 3; i++) chk("hits", 16'(want[i]), 16'(hits[i]));
		tally_and_finish();
	end

	// Run is about 75 us; a hang ends well after that
	initial begin
		#200us;
		error_cnt++;
		tally_and_finish();
	end
endmodule : cpu_countdown_timers_tb
